// [hdl/ascd_device.sv]
// Device end: opcode decode, conversion control and result readout
// How it works
// - Single-byte opcodes; register ops take two bytes
// - Chip select low for a whole command
// - System opcodes and result read on seventh fall
// - Register opcodes decoded on eighth fall
// - Wakeup, standby, reset, start, stop opcodes
// - Continuous on/off and on-demand result read
// - Register byte: prefix, address; then count minus one
// - Register read ignored in continuous mode
// - Wakeup leaves standby; host waits four cycles
// - Standby halts everything but the reference
// - Reset restarts filter, restores register defaults
// - Host idles eighteen cycles after reset opcode
// - Start begins conversions; no effect when running
// - Host gaps four cycles from start to stop
// - Host holds start pin low under opcodes
// - Stop finishes current conversion, then halts
// - Continuous mode loads each result at ready
// - In continuous mode host leaves it first
// - Host waits four cycles after continuous entry
// - No continuous entry near the ready pulse
// - Host waits four cycles after continuous exit
// - On-demand read may overlap next ready safely
// - Four cycles between bytes of one command
module ascd_device (
    input  wire logic                          CLK,
    input  wire logic                          RESETN,
    ascd_link_if.device                        LINK,
    input  wire logic [ascd_pkg::RESULT_W-1:0] SAMPLE,
    output logic                               STANDBY,
    output logic                               CONVERTING,
    output logic                               CONTINUOUS,
    output logic                               RESET_BUSY
);
    // ==========================================================
    // Link input synchronisers
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] in_q;
    logic [3:0] prev_q;
    logic [3:0] in_d;

    assign in_d = (s3_q & ~(s2_q ^ s3_q)) | (in_q & (s2_q ^ s3_q));

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s1_q   <= ascd_pkg::LINK_IDLE;
            s2_q   <= ascd_pkg::LINK_IDLE;
            s3_q   <= ascd_pkg::LINK_IDLE;
            in_q   <= ascd_pkg::LINK_IDLE;
            prev_q <= ascd_pkg::LINK_IDLE;
        end else begin
            s1_q   <= {LINK.start_pin, LINK.din, LINK.cs_n, LINK.sclk};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            in_q   <= in_d;
            prev_q <= in_q;
        end
    end

    logic sel;
    logic sclk_fall;
    logic sclk_rise;
    logic din;

    assign sel       = ~in_q[ascd_pkg::LK_CSN];
    assign sclk_fall = sel & prev_q[ascd_pkg::LK_SCLK] & ~in_q[ascd_pkg::LK_SCLK];
    assign sclk_rise = sel & ~prev_q[ascd_pkg::LK_SCLK] & in_q[ascd_pkg::LK_SCLK];
    assign din       = in_q[ascd_pkg::LK_DIN];

    // ==========================================================
    // Byte assembly
    logic [2:0] bit_cnt_q;
    logic [6:0] sh_q;
    logic [7:0] byte_now;
    logic       fire7;
    logic       fire8;

    assign byte_now = {sh_q, din};
    assign fire7    = sclk_fall && bit_cnt_q == 3'h6;
    assign fire8    = sclk_fall && bit_cnt_q == 3'h7;

    always_ff @(posedge CLK) begin
        if (!RESETN || !sel) begin
            bit_cnt_q <= 3'h0;
            sh_q      <= 7'h00;
        end else if (sclk_fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            sh_q      <= byte_now[6:0];
        end
    end

    // Seven bits suffice for these, so they act a bit early
    function automatic logic early_op(input logic [6:0] b7);
        case ({b7, 1'b0})
            ascd_pkg::OP_WAKEUP, ascd_pkg::OP_STANDBY, ascd_pkg::OP_RESET,
            ascd_pkg::OP_START, ascd_pkg::OP_STOP, ascd_pkg::OP_RDATA: early_op = 1'b1;
            default: early_op = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Opcode decode
    ascd_pkg::ascd_dev_state_t state_q;
    logic       busy_q;
    logic       cont_q;
    logic       go7;
    logic       go8;
    logic [7:0] op7;

    assign op7 = {byte_now[6:0], 1'b0};
    assign go7 = fire7 && state_q == ascd_pkg::ST_OP && !busy_q && early_op(byte_now[6:0]);
    assign go8 = fire8 && state_q == ascd_pkg::ST_OP && !busy_q && !early_op(byte_now[7:1]);

    logic do_wakeup, do_standby, do_reset, do_start, do_stop, do_rdata;
    logic do_cont_on, do_cont_off, do_register_read_cmd, do_register_write_cmd;

    assign do_wakeup   = go7 && op7 == ascd_pkg::OP_WAKEUP;
    assign do_standby  = go7 && op7 == ascd_pkg::OP_STANDBY;
    assign do_reset    = go7 && op7 == ascd_pkg::OP_RESET;
    assign do_start    = go7 && op7 == ascd_pkg::OP_START;
    assign do_stop     = go7 && op7 == ascd_pkg::OP_STOP;
    assign do_rdata    = go7 && op7 == ascd_pkg::OP_RDATA;
    assign do_cont_on  = go8 && byte_now == ascd_pkg::OP_CONT_ON;
    assign do_cont_off = go8 && byte_now == ascd_pkg::OP_CONT_OFF;
    assign do_register_read_cmd     = go8 && byte_now[7:5] == ascd_pkg::PFX_REG_READ;
    assign do_register_write_cmd     = go8 && byte_now[7:5] == ascd_pkg::PFX_REG_WRITE;

    // ==========================================================
    // Register command sequencing
    logic       rd_q;
    logic [4:0] addr_q;
    logic [4:0] left_q;

    always_ff @(posedge CLK) begin
        if (!RESETN || !sel) begin
            state_q <= ascd_pkg::ST_OP;
            rd_q    <= 1'b0;
            addr_q  <= 5'h00;
            left_q  <= 5'h00;
        end else begin
            case (state_q)
                ascd_pkg::ST_OP: begin
                    if (do_register_read_cmd || do_register_write_cmd) begin
                        // Skip drops the rest of the frame so data is never taken as opcodes
                        state_q <= (do_register_read_cmd && cont_q) ? ascd_pkg::ST_SKIP
                                                       : ascd_pkg::ST_COUNT;
                        rd_q    <= do_register_read_cmd;
                        addr_q  <= byte_now[4:0];
                    end
                end
                ascd_pkg::ST_COUNT: begin
                    if (fire8) begin
                        left_q  <= byte_now[4:0];
                        state_q <= rd_q ? ascd_pkg::ST_READ : ascd_pkg::ST_WRITE;
                    end
                end
                ascd_pkg::ST_READ, ascd_pkg::ST_WRITE: begin
                    if (fire8) begin
                        if (left_q == 5'h00) begin
                            state_q <= ascd_pkg::ST_OP;
                        end else begin
                            addr_q <= addr_q + 5'h01;
                            left_q <= left_q - 5'h01;
                        end
                    end
                end
                ascd_pkg::ST_SKIP: state_q <= ascd_pkg::ST_SKIP;
                default: state_q <= ascd_pkg::ST_OP;
            endcase
        end
    end

    // ==========================================================
    // Register file
    logic [7:0] regs_q [ascd_pkg::REG_CNT];

    always_ff @(posedge CLK) begin
        if (!RESETN || do_reset) begin
            for (int i = 0; i < ascd_pkg::REG_CNT; i++) begin
                regs_q[i] <= ascd_pkg::REG_RESET_VAL;
            end
        end else if (fire8 && state_q == ascd_pkg::ST_WRITE) begin
            regs_q[addr_q] <= byte_now;
        end
    end

    // ==========================================================
    // Modes and conversion control
    logic       standby_q;
    logic       conv_on_q;
    logic       stop_pend_q;
    logic [4:0] busy_cnt_q;
    logic [7:0] conv_cnt_q;
    logic       run;
    logic       done;

    assign run  = (conv_on_q | in_q[ascd_pkg::LK_START]) & ~standby_q & ~busy_q;
    assign done = run && conv_cnt_q == ascd_pkg::CONV_LAST;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            standby_q <= 1'b0;
            cont_q    <= 1'b1;
        end else begin
            if (do_standby) standby_q <= 1'b1;
            if (do_wakeup) standby_q <= 1'b0;
            if (do_cont_on) cont_q <= 1'b1;
            if (do_cont_off) cont_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= 5'h00;
        end else if (do_reset) begin
            busy_q     <= 1'b1;
            busy_cnt_q <= ascd_pkg::RESET_LOAD;
        end else if (busy_cnt_q != 5'h00) begin
            busy_cnt_q <= busy_cnt_q - 5'h01;
        end else begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            conv_on_q   <= 1'b0;
            stop_pend_q <= 1'b0;
        end else begin
            if (do_start) conv_on_q <= 1'b1;
            if (do_stop) stop_pend_q <= conv_on_q;
            if (done && stop_pend_q) begin
                conv_on_q   <= 1'b0;
                stop_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN || do_reset || !run || done) begin
            conv_cnt_q <= 8'h00;
        end else begin
            conv_cnt_q <= conv_cnt_q + 8'h01;
        end
    end

    // ==========================================================
    // Result, readout shift and data ready
    logic [ascd_pkg::RESULT_W-1:0] result_q;
    logic [ascd_pkg::RESULT_W-1:0] out_q;
    logic                          dout_q;
    logic                          data_ready_n_n_q;
    logic                          load_reg;
    logic [4:0]                    load_addr;

    assign load_reg  = fire8 && ((state_q == ascd_pkg::ST_COUNT && rd_q) ||
                                 (state_q == ascd_pkg::ST_READ && left_q != 5'h00));
    assign load_addr = (state_q == ascd_pkg::ST_COUNT) ? addr_q : addr_q + 5'h01;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            result_q <= '0;
            out_q    <= '0;
            dout_q   <= 1'b0;
        end else begin
            if (done) result_q <= SAMPLE;
            if (load_reg) begin
                out_q <= {regs_q[load_addr], (ascd_pkg::RESULT_W - 8)'(0)};
            end else if (do_rdata) begin
                out_q <= {result_q[0], result_q[ascd_pkg::RESULT_W-1:1]};
            end else if (done && cont_q) begin
                out_q <= SAMPLE;
            end else if (sclk_rise) begin
                // Rotation makes repeated reads return the same word again
                out_q <= {out_q[ascd_pkg::RESULT_W-2:0], out_q[ascd_pkg::RESULT_W-1]};
            end
            if (sclk_rise) dout_q <= out_q[ascd_pkg::RESULT_W-1];
        end
    end

    // Without continuous mode a new result only lands in result_q: no overlap damage
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            data_ready_n_n_q <= 1'b1;
        end else if (done) begin
            data_ready_n_n_q <= 1'b0;
        end else if (sclk_fall || (run && conv_cnt_q == ascd_pkg::UPDATE_AT)) begin
            data_ready_n_n_q <= 1'b1;
        end
    end

    assign LINK.dout         = dout_q;
    assign LINK.data_ready_n = data_ready_n_n_q;
    assign STANDBY           = standby_q;
    assign CONVERTING        = conv_on_q;
    assign CONTINUOUS        = cont_q;
    assign RESET_BUSY        = busy_q;
endmodule

// [hdl/ascd_host.sv]
// Host end: byte sender with command wait periods
module ascd_host (
    input  wire logic       CLK,
    input  wire logic       RESETN,
    ascd_link_if.host       LINK,
    input  wire logic       BYTE_VALID,
    input  wire logic [7:0] BYTE_DATA,
    input  wire logic       BYTE_LAST,
    output logic            BYTE_READY,
    output logic            RX_VALID,
    output logic [7:0]      RX_DATA,
    output logic            REFUSED,
    output logic            DATA_READY
);
    // ==========================================================
    // Link input synchronisers
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] in_q;
    logic [1:0] in_d;

    assign in_d = (s3_q & ~(s2_q ^ s3_q)) | (in_q & (s2_q ^ s3_q));

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s1_q <= 2'h2;
            s2_q <= 2'h2;
            s3_q <= 2'h2;
            in_q <= 2'h2;
        end else begin
            s1_q <= {LINK.data_ready_n, LINK.dout};
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= in_d;
        end
    end

    // Cycles since the ready line last moved, saturating
    logic [2:0] quiet_q;

    always_ff @(posedge CLK) begin
        if (!RESETN || in_q[1] != in_d[1]) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end

    // ==========================================================
    // Byte sequencer
    ascd_pkg::ascd_host_state_t state_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] din_sent_q;
    logic       last_q;
    logic       first_q;
    logic       cont_q;
    logic [2:0] ph_q;
    logic [4:0] hcnt_q;
    logic [4:0] gap_q;
    logic       sclk_q;
    logic       csn_q;
    logic       din_q;
    logic       ready_q;
    logic       rxv_q;
    logic       ref_q;
    logic       data_ready_n_q;
    logic       take;
    logic       refuse;
    logic       half;

    assign take   = BYTE_VALID && ready_q;
    // Only the exit opcode or filler clocks are legal while continuous
    assign refuse = first_q && cont_q && BYTE_DATA != ascd_pkg::OP_CONT_OFF &&
                    BYTE_DATA != ascd_pkg::OP_FILLER;
    assign half   = ph_q == ascd_pkg::SCLK_HALF;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_q <= ascd_pkg::HS_IDLE;
            tx_q    <= 8'h00;
            rx_q    <= 8'h00;
            last_q  <= 1'b0;
            first_q <= 1'b1;
            cont_q  <= 1'b1;
            ph_q    <= 3'h0;
            hcnt_q  <= 5'h00;
            gap_q   <= 5'h00;
            sclk_q  <= 1'b0;
            csn_q   <= 1'b1;
            din_q   <= 1'b0;
            ready_q <= 1'b1;
            rxv_q   <= 1'b0;
            ref_q   <= 1'b0;
        end else begin
            rxv_q <= 1'b0;
            ref_q <= 1'b0;
            case (state_q)
                ascd_pkg::HS_IDLE: begin
                    if (take && refuse) begin
                        ref_q <= 1'b1;
                    end else if (take) begin
                        ready_q <= 1'b0;
                        tx_q    <= BYTE_DATA;
                        last_q  <= BYTE_LAST;
                        state_q <= ascd_pkg::HS_HOLD;
                    end
                end
                ascd_pkg::HS_HOLD: begin
                    // Keep continuous entry clear of the ready edge
                    if (!(first_q && tx_q == ascd_pkg::OP_CONT_ON &&
                          quiet_q < 3'(ascd_pkg::DECODE_CYC))) begin
                        csn_q   <= 1'b0;
                        ph_q    <= 3'h0;
                        hcnt_q  <= 5'h00;
                        state_q <= ascd_pkg::HS_SHIFT;
                    end
                end
                ascd_pkg::HS_SHIFT: begin
                    ph_q <= half ? 3'h0 : ph_q + 3'h1;
                    if (half) begin
                        hcnt_q <= hcnt_q + 5'h01;
                        if (!hcnt_q[0] && hcnt_q != 5'h10) begin
                            sclk_q <= 1'b1;
                            din_q  <= tx_q[7];
                            tx_q   <= {tx_q[6:0], 1'b0};
                        end else if (hcnt_q[0]) begin
                            sclk_q <= 1'b0;
                        end
                        // Sample three halves after the rise: dout returns through two syncs
                        if (hcnt_q[0] && hcnt_q != 5'h01) begin
                            rx_q <= {rx_q[6:0], in_q[0]};
                        end
                        if (hcnt_q == 5'h11) begin
                            rxv_q   <= 1'b1;
                            state_q <= ascd_pkg::HS_GAP;
                            // Wait periods after each byte, longer after reset
                            gap_q   <= first_op_is_reset(first_q && last_q, din_sent_q)
                                       ? ascd_pkg::RESET_LOAD : ascd_pkg::DECODE_LOAD;
                        end
                    end
                end
                ascd_pkg::HS_GAP: begin
                    if (gap_q != 5'h00) begin
                        gap_q <= gap_q - 5'h01;
                    end else begin
                        csn_q   <= last_q ? 1'b1 : 1'b0;
                        first_q <= last_q;
                        ready_q <= 1'b1;
                        state_q <= ascd_pkg::HS_IDLE;
                    end
                end
                default: state_q <= ascd_pkg::HS_IDLE;
            endcase
            if (take && !refuse && first_q && BYTE_DATA == ascd_pkg::OP_CONT_ON) cont_q <= 1'b1;
            if (take && !refuse && first_q && BYTE_DATA == ascd_pkg::OP_CONT_OFF) cont_q <= 1'b0;
        end
    end

    // Opcode of the byte in flight, kept for the gap choice

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            din_sent_q <= 8'h00;
        end else if (take && state_q == ascd_pkg::HS_IDLE) begin
            din_sent_q <= BYTE_DATA;
        end
    end

    function automatic logic first_op_is_reset(input logic first, input logic [7:0] op);
        first_op_is_reset = first && op == ascd_pkg::OP_RESET;
    endfunction

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            data_ready_n_q <= 1'b0;
        end else begin
            data_ready_n_q <= ~in_q[1];
        end
    end

    assign LINK.sclk      = sclk_q;
    assign LINK.cs_n      = csn_q;
    assign LINK.din       = din_q;
    assign LINK.start_pin = 1'b0;
    assign BYTE_READY     = ready_q;
    assign RX_VALID       = rxv_q;
    assign RX_DATA        = rx_q;
    assign REFUSED        = ref_q;
    assign DATA_READY     = data_ready_n_q;
endmodule

// [hdl/ascd_link_if.sv]
// Serial link wires between host and converter front end
interface ascd_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic data_ready_n;
    logic start_pin;

    modport device (
        input  sclk,
        input  cs_n,
        input  din,
        input  start_pin,
        output dout,
        output data_ready_n
    );

    modport host (
        output sclk,
        output cs_n,
        output din,
        output start_pin,
        input  dout,
        input  data_ready_n
    );
endinterface

// [hdl/ascd_pkg.sv]
// Shared constants and types for the serial command link
package ascd_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_DECODE_NS   = 40;
    localparam int T_RESET_NS    = 180;
    localparam int DECODE_CYC    = (T_DECODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYC     = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] DECODE_LOAD = 5'(DECODE_CYC - 1);
    localparam logic [4:0] RESET_LOAD  = 5'(RESET_CYC - 1);
    localparam logic [2:0] SCLK_HALF   = 3'h3;
    localparam logic [7:0] CONV_LAST   = 8'hFF;
    localparam logic [7:0] UPDATE_AT   = 8'(CONV_LAST - 8'(DECODE_CYC));

    // ==========================================================
    // Sizes, link bit positions, reset values
    localparam int RESULT_W = 16;
    localparam int REG_CNT  = 32;
    localparam int LK_SCLK  = 0;
    localparam int LK_CSN   = 1;
    localparam int LK_DIN   = 2;
    localparam int LK_START = 3;
    localparam logic [3:0] LINK_IDLE     = 4'h2;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_WAKEUP   = 8'h02;
    localparam logic [7:0] OP_STANDBY  = 8'h04;
    localparam logic [7:0] OP_RESET    = 8'h06;
    localparam logic [7:0] OP_START    = 8'h08;
    localparam logic [7:0] OP_STOP     = 8'h0A;
    localparam logic [7:0] OP_CONT_ON  = 8'h10;
    localparam logic [7:0] OP_CONT_OFF = 8'h11;
    localparam logic [7:0] OP_RDATA    = 8'h12;
    localparam logic [7:0] OP_FILLER   = 8'h00;
    localparam logic [2:0] PFX_REG_READ  = 3'h1;
    localparam logic [2:0] PFX_REG_WRITE = 3'h2;

    // ==========================================================
    // State types
    typedef enum logic [4:0] {
        ST_OP    = 5'h01,
        ST_COUNT = 5'h02,
        ST_READ  = 5'h04,
        ST_WRITE = 5'h08,
        ST_SKIP  = 5'h10
    } ascd_dev_state_t;

    typedef enum logic [3:0] {
        HS_IDLE  = 4'h1,
        HS_HOLD  = 4'h2,
        HS_SHIFT = 4'h4,
        HS_GAP   = 4'h8
    } ascd_host_state_t;
endpackage

// [verification/ascd_link_sva.sv]
// Link protocol assertions for the serial command link
module ascd_link_sva (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic data_ready_n,
    input wire logic start_pin
);
    // ====================
    // Link framing
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sel_hold_a: assert property (sclk |-> !cs_n) else $error("clock outside select");
    pin_low_a: assert property (!start_pin) else $error("start pin not low");
    din_hold_a: assert property (sclk && $past(sclk) |-> $stable(din))
        else $error("data moved while clock high");
    clk_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("clock high phase wrong");
    byte_gap_a: assert property ($fell(sclk) |-> !sclk[*4]) else $error("clock low too short");
    frame_end_a: assert property ($rose(cs_n) |-> !$past(sclk, 4))
        else $error("select released early");
    frame_lead_a: assert property ($fell(cs_n) |-> !sclk[*3])
        else $error("clock too soon after select");
    reset_idle_a: assert property (disable iff (1'b0) !RESETN |=> cs_n && !sclk && data_ready_n)
        else $error("link not idle in reset");
endmodule

// [verification/tb.sv]
// Testbench joining host and device ends over the serial link
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, byte_valid = 0, byte_last = 0, refd;
    logic [7:0] byte_data = 8'h00, rx, rx_data, d0, d1;
    logic [15:0] sample = 16'h0000;
    logic [4:0] addr;
    logic byte_ready, rx_valid, refused, data_ready, stby, conv, cont, rbusy;
    logic [31:0] seed = 32'h00008FD6;
    logic [1:0] m = 2'h0;
    logic [7:0] ops [5] = '{8'h04, 8'h02, 8'h0A, 8'h08, 8'h08};
    int err_count = 0, checks_done = 0, cyc = 0, busy_n = 0, i;
    ascd_link_if link ();
    ascd_device u_ascd_device (.CLK(clk), .RESETN(resetn), .LINK(link), .SAMPLE(sample),
        .STANDBY(stby), .CONVERTING(conv), .CONTINUOUS(cont), .RESET_BUSY(rbusy));
    ascd_host u_ascd_host (.CLK(clk), .RESETN(resetn), .LINK(link), .BYTE_VALID(byte_valid),
        .BYTE_DATA(byte_data), .BYTE_LAST(byte_last), .BYTE_READY(byte_ready),
        .RX_VALID(rx_valid), .RX_DATA(rx_data), .REFUSED(refused), .DATA_READY(data_ready));
    ascd_link_sva u_ascd_link_sva (.CLK(clk), .RESETN(resetn), .sclk(link.sclk),
        .cs_n(link.cs_n), .din(link.din), .data_ready_n(link.data_ready_n),
        .start_pin(link.start_pin));
    always #5 clk = ~clk;
    // ====================
    // Helpers
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] mode_after(input logic [7:0] op, input logic [1:0] p);
        case (op)
            8'h04: return 2'h2;
            8'h02: return {1'b0, p[0]};
            8'h08: return {p[1], 1'b1};
            8'h0A: return {p[1], 1'b0};
            default: return p;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] b, input logic l);
        int n;
        for (n = 0; n < 400 && byte_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        byte_valid <= 1'b1;
        byte_data <= b;
        byte_last <= l;
        @(posedge clk);
        byte_valid <= 1'b0;
        @(negedge clk);
        for (n = 0; n < 300 && rx_valid !== 1'b1 && refused !== 1'b1; n++) @(negedge clk);
        rx = rx_data;
        refd = refused;
        for (n = 0; n < 400 && byte_ready !== 1'b1; n++) @(negedge clk);
    endtask
    // ====================
    // Watchdog and reset-busy length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    always @(negedge clk) busy_n += (rbusy === 1'b1);
    // ====================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk({stby, conv, cont, rbusy}, 16'h2);
        xfer(8'h11, 1'b1);
        chk(cont, 16'h0);
        @(posedge clk) sample <= 16'(xorshift());
        for (i = 0; i < 5; i++) begin
            xfer(ops[i], 1'b1);
            m = mode_after(ops[i], m);
            chk({stby, conv}, m);
        end
        for (i = 0; i < 400 && data_ready !== 1'b1; i++) @(negedge clk);
        chk(data_ready, 16'h1);
        xfer(8'h12, 1'b0);
        xfer(8'h00, 1'b0);
        d0 = rx;
        xfer(8'h00, 1'b1);
        chk({d0, rx}, sample);
        xfer(8'h0A, 1'b1);
        repeat (300) @(negedge clk);
        chk(conv, 16'h0);
        addr = 5'(xorshift()) & 5'h1E;
        d0 = 8'(xorshift());
        d1 = 8'(xorshift());
        xfer({3'h2, addr}, 1'b0);
        xfer(8'h01, 1'b0);
        xfer(d0, 1'b0);
        xfer(d1, 1'b1);
        xfer({3'h1, addr}, 1'b0);
        xfer(8'h01, 1'b0);
        xfer(8'h00, 1'b0);
        chk(rx, d0);
        xfer(8'h00, 1'b1);
        chk(rx, d1);
        xfer(8'h06, 1'b1);
        xfer(8'h11, 1'b1);
        xfer({3'h1, addr}, 1'b0);
        xfer(8'h00, 1'b0);
        xfer(8'h00, 1'b1);
        chk(rx, 16'h0);
        chk(16'(busy_n), 16'h12);
        xfer(8'h10, 1'b1);
        chk(cont, 16'h1);
        xfer({3'h1, addr}, 1'b1);
        chk(refd, 16'h1);
        xfer(8'h11, 1'b1);
        chk(cont, 16'h0);
        end_sim();
    end
endmodule
